// ===== core/adcss_setup.sv
`timescale 1ns/10ps
module adcss_setup #(
  parameter int RES_W = adcss_pkg::RESULT_W
) (
  clk,             // System clock, 10 MHz
  srst,            // Synchronous reset, active high
  sclk,            // Serial clock, sampled
  cs_n,            // Chip select, active low
  din,             // Serial data in
  result,          // Conversion result of current channel
  dout,            // Serial data out
  mux_chan,        // Channel on analog multiplexer
  conv_start,      // Pulse: conversion starts at select fall
  cfg,             // Active configuration
  setup_word       // Stored setup word
);
  input  wire logic              clk;
  input  wire logic              srst;
  input  wire logic              sclk;
  input  wire logic              cs_n;
  input  wire logic              din;
  input  wire logic [RES_W-1:0]  result;
  output logic                   dout;
  output logic [1:0]             mux_chan;
  output logic                   conv_start;
  output adcss_pkg::adcss_cfg_t  cfg;
  output logic [11:0]            setup_word;

  adcss_pkg::adcss_state_t state_reg;
  adcss_pkg::adcss_state_t state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] chan_of(input logic [11:0] w);
    // Index decode
    // plain binary
    chan_of = {w[adcss_pkg::POS_CHAN_HIGH], w[adcss_pkg::POS_CHAN_LOW]};
  endfunction : chan_of

  function automatic adcss_pkg::adcss_seq_t seq_of(input logic [11:0] w);
    seq_of = adcss_pkg::adcss_seq_t'({w[adcss_pkg::POS_SEQ_HIGH], w[adcss_pkg::POS_SEQ_LOW]});
  endfunction : seq_of

  logic        fall;
  logic [11:0] word_in;
  logic [11:0] merged;
  logic [1:0]  next_chan;
  logic        sweeping;

  always_comb begin
    state_next = state_reg;
    state_next.start_pulse = 1'b0;
    state_next.sclk_prev = sclk;
    fall = state_reg.sclk_prev & ~sclk;
    word_in = state_reg.shift_in;
    merged = state_reg.setup;
    next_chan = state_reg.conv_chan;
    sweeping = state_reg.seq_active;

    unique case (state_reg.phase)
      adcss_pkg::ST_IDLE: begin
        if (!cs_n) begin
          state_next.phase = adcss_pkg::ST_FRAME;
          state_next.edge_cnt = adcss_pkg::CNT_RESET;
          state_next.start_pulse = 1'b1;
          state_next.conv_chan = state_reg.mux_chan;
          state_next.shift_out = {2'h0, state_reg.mux_chan, result[RES_W-1 -: 12]};
          state_next.dout = 1'b0;
        end
      end
      adcss_pkg::ST_FRAME: begin
        if (cs_n) begin
          // Frame cut short: setup applied only if the 14th falling edge was reached
          state_next.phase = adcss_pkg::ST_IDLE;
        end else if (fall) begin
          state_next.edge_cnt = state_reg.edge_cnt + 5'h01;
          state_next.dout = state_reg.shift_out[15];
          state_next.shift_out = {state_reg.shift_out[14:0], 1'b0};
          if (state_reg.edge_cnt < 5'(adcss_pkg::SETUP_W)) begin
            word_in = {state_reg.shift_in[10:0], din};
            state_next.shift_in = word_in;
          end
          if (state_reg.edge_cnt == 5'(adcss_pkg::MUX_EDGE - 1)) begin
            if (state_reg.shift_in[adcss_pkg::POS_WRITE_EN]) begin
              merged = state_reg.shift_in;
            end
            merged[9:8] = 2'h0;
            merged[2] = 1'b0;
            state_next.setup = merged;
            unique case (seq_of(merged))
              adcss_pkg::SEQ_OFF_A, adcss_pkg::SEQ_OFF_B: begin
                sweeping = 1'b0;
                next_chan = chan_of(merged);
              end
              adcss_pkg::SEQ_KEEP: begin
                next_chan = sweeping ? ((state_reg.conv_chan >= chan_of(merged)) ? 2'h0
                                        : state_reg.conv_chan + 2'h1) : chan_of(merged);
              end
              adcss_pkg::SEQ_SWEEP: begin
                if (state_reg.shift_in[adcss_pkg::POS_WRITE_EN]) begin
                  sweeping = 1'b1;
                  next_chan = 2'h0;
                end else begin
                  next_chan = (state_reg.conv_chan >= chan_of(merged)) ? 2'h0
                              : state_reg.conv_chan + 2'h1;
                end
              end
            endcase
            state_next.seq_active = sweeping;
            state_next.mux_chan = next_chan;
          end
          if (state_reg.edge_cnt == 5'(adcss_pkg::FRAME_LEN - 1)) begin
            state_next.phase = adcss_pkg::ST_IDLE;
          end
        end
      end
    endcase

    if (srst) begin
      state_next = '0;
      state_next.setup = adcss_pkg::SETUP_RESET;
      state_next.sclk_prev = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dout = state_reg.dout;
  assign mux_chan = state_reg.mux_chan;
  assign conv_start = state_reg.start_pulse;
  assign setup_word = state_reg.setup;

  always_comb begin
    cfg.channel = state_reg.conv_chan;
    cfg.power_mode = adcss_pkg::adcss_pwr_t'({state_reg.setup[adcss_pkg::POS_PWR_HIGH],
                                              state_reg.setup[adcss_pkg::POS_PWR_LOW]});
    cfg.input_span_ref = state_reg.setup[adcss_pkg::POS_RANGE];
    cfg.straight_binary = state_reg.setup[adcss_pkg::POS_CODING];
    // shutdown decode; invalid code treated as normal
    cfg.power_down = (cfg.power_mode == adcss_pkg::PWR_FULL_SHDN) ||
                     ((cfg.power_mode == adcss_pkg::PWR_AUTO_SHDN) && (state_reg.phase == adcss_pkg::ST_IDLE));
  end

endmodule : adcss_setup

// ===== core/adcss_pkg.sv
package adcss_pkg;

  // ----------------------------------------------------------------
  // Setup word layout
  // ----------------------------------------------------------------
  localparam int SETUP_W        = 12;
  localparam int FRAME_LEN      = 16;
  localparam int POS_WRITE_EN   = 11;
  localparam int POS_SEQ_HIGH   = 10;
  localparam int POS_CHAN_HIGH  = 7;
  localparam int POS_CHAN_LOW   = 6;
  localparam int POS_PWR_HIGH   = 5;
  localparam int POS_PWR_LOW    = 4;
  localparam int POS_SEQ_LOW    = 3;
  localparam int POS_RANGE      = 1;
  localparam int POS_CODING     = 0;
  localparam int MUX_EDGE       = 14;
  localparam int CHAN_W         = 2;
  localparam int RESULT_W       = 12;

  localparam logic [11:0] SETUP_RESET = 12'h030;
  localparam logic [4:0]  CNT_RESET   = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_INVALID   = 2'h0,
    PWR_AUTO_SHDN = 2'h1,
    PWR_FULL_SHDN = 2'h2,
    PWR_NORMAL    = 2'h3
  } adcss_pwr_t;

  typedef enum logic [1:0] {
    SEQ_OFF_A  = 2'h0,
    SEQ_OFF_B  = 2'h1,
    SEQ_KEEP   = 2'h2,
    SEQ_SWEEP  = 2'h3
  } adcss_seq_t;

  typedef enum logic {
    ST_IDLE,
    ST_FRAME
  } adcss_phase_t;

  typedef struct packed {
    logic [1:0] channel;
    adcss_pwr_t power_mode;
    logic       input_span_ref;
    logic       straight_binary;
    logic       power_down;
  } adcss_cfg_t;

  typedef struct packed {
    adcss_phase_t phase;
    logic [4:0]   edge_cnt;
    logic [11:0]  shift_in;
    logic [11:0]  setup;
    logic [15:0]  shift_out;
    logic         dout;
    logic [1:0]   mux_chan;
    logic [1:0]   conv_chan;
    logic         seq_active;
    logic         start_pulse;
    logic         sclk_prev;
  } adcss_state_t;

endpackage : adcss_pkg

// ===== verif/adcss_setup_assertions.sv
`timescale 1ns/10ps
module adcss_setup_assertions #(
  parameter int RES_W = 12
) (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  sclk,
  input wire logic                  cs_n,
  input wire logic                  din,
  input wire logic [RES_W-1:0]      result,
  input wire logic                  dout,
  input wire logic [1:0]            mux_chan,
  input wire logic                  conv_start,
  input wire adcss_pkg::adcss_cfg_t cfg,
  input wire logic [11:0]           setup_word
);
  // ------------
  // Frame shadow
  // ------------
  logic             sclk_reg;
  logic             infr_reg;
  logic [4:0]       cnt_reg;
  logic [11:0]      sh_reg;
  logic [RES_W-1:0] res_reg;
  logic             fall;
  logic [RES_W+3:0] frm;
  assign fall = sclk_reg & ~sclk & ~cs_n & infr_reg;
  assign frm = {2'b00, cfg.channel, res_reg};
  always_ff @(posedge clk) begin
    sclk_reg <= srst | sclk;
    if (srst | cs_n) begin
      infr_reg <= 1'b0;
      cnt_reg <= 5'h00;
    end else if (!infr_reg) begin
      infr_reg <= 1'b1;
      res_reg <= result;
    end else if (fall) begin
      cnt_reg <= cnt_reg + 5'h01;
      infr_reg <= (cnt_reg != 5'h0F);
      if (cnt_reg < 5'h0C) begin
        sh_reg <= {sh_reg[10:0], din};
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_fall14;
    fall && cnt_reg == 5'h0D;
  endsequence
  chk_start_pulse: assert property (!cs_n && !infr_reg |=> conv_start)
    else $error("no start pulse");
  chk_word_store: assert property (s_fall14 ##0 sh_reg[11] |=> setup_word == (sh_reg & 12'hCFB))
    else $error("word not stored");
  chk_word_keep: assert property (s_fall14 ##0 !sh_reg[11] |=> $stable(setup_word))
    else $error("word overwritten");
  chk_setup_hold: assert property (!(fall && cnt_reg == 5'h0D) |=> $stable({setup_word, mux_chan}))
    else $error("setup changed early");
  chk_mux_next: assert property (s_fall14 ##0 (sh_reg[11] && !sh_reg[10]) |=> mux_chan == sh_reg[7:6])
    else $error("wrong next channel");
  chk_frame_bits: assert property (fall |=> dout == frm[RES_W + 3 - $past(cnt_reg)])
    else $error("wrong output bit");
  chk_dout_hold: assert property (infr_reg && !fall |=> $stable(dout))
    else $error("output moved off edge");
  chk_span_code: assert property ({cfg.input_span_ref, cfg.straight_binary} == setup_word[1:0])
    else $error("span or coding wrong");
  chk_power_field: assert property (cfg.power_mode == setup_word[5:4])
    else $error("power field wrong");
  chk_power_down: assert property (cfg.power_down == ((setup_word[5:4] == 2'h2) || ((setup_word[5:4] == 2'h1) && !infr_reg)))
    else $error("power down wrong");
  chk_sweep_start: assert property (s_fall14 ##0 (sh_reg[11] && sh_reg[10] && sh_reg[3]) |=> mux_chan == 2'h0)
    else $error("sweep not from zero");
endmodule : adcss_setup_assertions
bind adcss_setup adcss_setup_assertions #(.RES_W(RES_W)) u_chk (
  .clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din), .result(result), .dout(dout),
  .mux_chan(mux_chan), .conv_start(conv_start), .cfg(cfg), .setup_word(setup_word));

// ===== verif/adcss_host.sv
`timescale 1ns/10ps
module adcss_host (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [1:0]  slow,
  input  wire logic [11:0] word,
  input  wire logic        dout,
  output logic             sclk,
  output logic             cs_n,
  output logic             din,
  output logic [15:0]      rx,
  output logic             done
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
    rx = 16'h0000;
    done = 1'b0;
  end
  always @(posedge clk) begin
    if (go) begin
      @(negedge clk);
      cs_n <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        din <= (i < 12) ? word[11 - i] : ~din;
        @(negedge clk);
        sclk <= 1'b0;
        @(negedge clk);
        rx <= {rx[14:0], dout};
        cs_n <= (i == 15);
        @(negedge clk);
        sclk <= 1'b1;
        repeat (slow + 1) @(negedge clk);
      end
      din <= ~din;
      done <= 1'b1;
      @(negedge clk);
      done <= 1'b0;
    end
  end
endmodule : adcss_host

// ===== verif/adcss_setup_tb_top.sv
`timescale 1ns/10ps
module adcss_setup_tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        go = 1'b0;
  logic [1:0]  slow = 2'h0;
  logic [11:0] word = 12'h000;
  logic [11:0] result = 12'h000;
  logic [15:0] rnd = 16'h0020;
  logic [11:0] exp_setup = 12'h030;
  logic [1:0]  exp_chan = 2'h0;
  logic        swp = 1'b0;
  logic [29:0] notes[$];
  int          mismatches = 0;
  int          n_compared = 0;
  int          cycles = 0;
  wire         sclk, cs_n, din, dout, done;
  wire [15:0]  rx;
  wire [1:0]   mux_chan;
  wire [11:0]  setup_word;
  always #50 clk = ~clk;
  adcss_setup dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din), .result(result),
    .dout(dout), .mux_chan(mux_chan), .conv_start(), .cfg(), .setup_word(setup_word));
  adcss_host host (.clk(clk), .go(go), .slow(slow), .word(word), .dout(dout), .sclk(sclk),
    .cs_n(cs_n), .din(din), .rx(rx), .done(done));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [29:0] got, input logic [29:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // Frame carries the old channel tag, then loads the new word when its bit 11 is set
  task automatic frame(input logic [11:0] w);
    logic [15:0] exp_rx;
    rnd = lfsr(rnd);
    result <= rnd[11:0];
    slow <= rnd[13:12];
    word <= w;
    go <= 1'b1;
    exp_rx = {2'b00, exp_chan, rnd[11:0]};
    if (w[11]) begin
      exp_setup = w & 12'hCFB;
    end
    // Sequencer: off follows address, sweep restarts at 0 and wraps
    if (!exp_setup[10]) begin
      swp = 1'b0;
      exp_chan = exp_setup[7:6];
    end else if (w[11] && exp_setup[3]) begin
      swp = 1'b1;
      exp_chan = 2'h0;
    end else if (swp) begin
      exp_chan = (exp_chan >= exp_setup[7:6]) ? 2'h0 : exp_chan + 2'h1;
    end else begin
      exp_chan = exp_setup[7:6];
    end
    notes.push_back({exp_rx, exp_chan, exp_setup});
    @(negedge clk);
    go <= 1'b0;
    while (!done) @(negedge clk);
  endtask : frame
  // ------------------------
  // Result watcher, timeout
  // ------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end else if (done) begin
      chk({rx, mux_chan, setup_word}, notes.pop_front());
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    srst <= 1'b0;
    chk({18'h0, setup_word}, {18'h0, adcss_pkg::SETUP_RESET});
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      frame({i != 5, 1'b0, rnd[9:8], (i < 4) ? i[1:0] : rnd[7:6], rnd[5:0]});
    end
    // Sweep up to channel 2, keep it running, then leave it
    frame(12'hCB8);
    repeat (4) frame(12'h000);
    frame(12'hCB1);
    frame(12'h8F0);
    wrap_up();
  end
endmodule : adcss_setup_tb_top
